// *** hdl/bbm_pkg.sv ***
// shared constants and types for the bit-branch, memory map and clock block
package bbm_pkg;
   // =====================================================
   // bit-branch opcode layout
   localparam logic [3:0]  BBX_LOW_NIBBLE = 4'hf;  // low nibble shared by both bit branches
   localparam int          OP_SENSE_BIT   = 7;     // 1: branch if set, 0: branch if clear
   localparam int          OP_IDX_HI      = 6;     // 3-bit bit-select field, high end
   localparam int          OP_IDX_LO      = 4;     // 3-bit bit-select field, low end
   localparam logic [15:0] PC_STEP        = 16'h0001;
   localparam logic [15:0] BBX_LENGTH     = 16'h0003;
   localparam logic [7:0]  ZERO_PAGE_HI   = 8'h00;

   // =====================================================
   // memory map
   localparam logic [15:0] ROM_LO         = 16'h7f00;
   localparam logic [15:0] ROM_HI         = 16'h7fff;
   localparam logic [15:0] VEC_LO         = 16'hfffa;
   localparam logic [15:0] RAM_LO         = 16'h0040;
   localparam logic [15:0] RAM_HI         = 16'h00ff;
   localparam logic [15:0] STANDBY_HI     = 16'h005f;
   localparam logic [15:0] RST_VEC_ROM    = 16'h7ffe;
   localparam logic [15:0] RST_VEC_EXT    = 16'hfffc;

   // =====================================================
   // mode control register
   localparam logic [7:0]  MODE_CTRL_RESET = 8'h00;

   // =====================================================
   // sequencer states
   typedef enum logic [2:0] {
      S_IDLE,
      S_OPCODE,
      S_ZPADDR,
      S_DISP,
      S_OPERAND,
      S_DONE
   } seq_state_t;
endpackage

// *** hdl/bbm_if.sv ***
// interfaces between the top module and its decoder and clock submodules
`timescale 1ns/1ps
// =====================================================
// address decode carrier
interface map_if;
   logic [15:0] addr;
   logic        rom_sel;
   logic        ram_sel;
   logic        standby_sel;
   logic        vector_sel;
   logic [15:0] reset_vector;
   modport dec (input addr, output rom_sel, ram_sel, standby_sel, vector_sel, reset_vector);
   modport usr (output addr, input rom_sel, ram_sel, standby_sel, vector_sel, reset_vector);
endinterface

// =====================================================
// phase-two timing carrier
interface phase_if;
   logic tick;
   logic phase;
   modport gen (output tick, phase);
   modport usr (input tick, phase);
endinterface

// *** hdl/addr_map_decode.sv ***
// on-chip memory map decode for rom, vectors and page-zero ram
`timescale 1ns/1ps
module addr_map_decode #(
   parameter bit ROM_PRESENT  = 1'b1,
   parameter bit RESET_AT_ROM = 1'b0
) (
   map_if.dec m
);
   // =====================================================
   // region decode; rom region vanishes on the rom-less build
   assign m.rom_sel     = ROM_PRESENT && (m.addr >= bbm_pkg::ROM_LO)
                          && (m.addr <= bbm_pkg::ROM_HI);
   assign m.vector_sel  = (m.addr >= bbm_pkg::VEC_LO);
   assign m.ram_sel     = (m.addr >= bbm_pkg::RAM_LO)
                          && (m.addr <= bbm_pkg::RAM_HI);
   assign m.standby_sel = (m.addr >= bbm_pkg::RAM_LO)
                          && (m.addr <= bbm_pkg::STANDBY_HI);
   // rom-less build always takes the high reset vector
   assign m.reset_vector = (ROM_PRESENT && RESET_AT_ROM) ? bbm_pkg::RST_VEC_ROM
                                                        : bbm_pkg::RST_VEC_EXT;
endmodule

// *** hdl/clk_countdown.sv ***
// phase-two generation: countdown, bypass, master drive and slave input
`timescale 1ns/1ps
module clk_countdown #(
   parameter bit DIV_BY_FOUR = 1'b0,
   parameter bit SLAVE_MODE  = 1'b0
) (
   // clock and reset
   input  wire logic sys_clk_in,
   input  wire logic reset_n_in,
   // oscillator and phase-two pins
   input  wire logic osc_in,
   input  wire logic osc_out_pin_in,
   input  wire logic phi2_pin_in,
   output logic      phi2_pin_out,
   output logic      phi2_oe_out,
   // timing to the sequencer
   phase_if.gen      p
);
   typedef struct packed {
      logic       osc_s1;
      logic       osc_s2;
      logic       gnd_s1;
      logic       gnd_s2;
      logic       phi_s1;
      logic       phi_s2;
      logic       osc_prev;
      logic [1:0] div_cnt;
      logic       phase;
      logic       phase_prev;
   } clk_state_t;

   clk_state_t q;
   clk_state_t d;

   // =====================================================
   // next state: pins pass two flops before any logic sees them
   always_comb begin
      d        = q;
      d.osc_s1 = osc_in;
      d.osc_s2 = q.osc_s1;
      d.gnd_s1 = osc_out_pin_in;
      d.gnd_s2 = q.gnd_s1;
      d.phi_s1 = phi2_pin_in;
      d.phi_s2 = q.phi_s1;
      d.osc_prev = q.osc_s2;
      // count oscillator rising edges; bit 0 halves, bit 1 quarters
      if (q.osc_s2 && !q.osc_prev) begin
         d.div_cnt = q.div_cnt + 2'b01;
      end
      if (SLAVE_MODE) begin
         d.phase = q.phi_s2;
      end else if (!q.gnd_s2) begin
         d.phase = q.osc_s2;
      end else begin
         d.phase = DIV_BY_FOUR ? q.div_cnt[1] : q.div_cnt[0];
      end
      d.phase_prev = q.phase;
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // =====================================================
   // master drives the buffered phase, slave leaves the pin as input
   assign phi2_pin_out = q.phase;
   assign phi2_oe_out  = !SLAVE_MODE;
   assign p.phase      = q.phase;
   assign p.tick       = q.phase && !q.phase_prev;

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);

   tick_width_a: assert property (p.tick |=> !p.tick)
      else $error("phase-two tick lasted more than one cycle");
   slave_follow_a: assert property (SLAVE_MODE && $rose(q.phi_s2) |=> p.tick)
      else $error("slave phase did not follow the phase-two pin");
endmodule

// *** hdl/bit_branch_memory_map_clock.sv ***
// bit-test branch sequencer with memory map decode and phase-two clocking
`timescale 1ns/1ps
module bit_branch_memory_map_clock #(
   parameter bit ROM_PRESENT  = 1'b1,
   parameter bit RESET_AT_ROM = 1'b0,
   parameter bit DIV_BY_FOUR  = 1'b0,
   parameter bit SLAVE_MODE   = 1'b0
) (
   // clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        reset_n_in,
   // execute request from the core
   input  wire logic        exec_start_in,
   input  wire logic [15:0] exec_pc_in,
   input  wire logic [7:0]  status_in,
   // memory read data
   input  wire logic [7:0]  mem_data_in,
   // mode control register write
   input  wire logic        mode_wr_in,
   input  wire logic [7:0]  mode_data_in,
   // oscillator and phase-two pins
   input  wire logic        oscillator_input_in,
   input  wire logic        oscillator_output_in,
   input  wire logic        phi2_in,
   output logic             phi2_out,
   output logic             phi2_oe_out,
   // execute answer
   output logic             exec_busy_out,
   output logic             exec_done_out,
   output logic             branch_taken_out,
   output logic             not_bit_branch_out,
   output logic [15:0]      next_pc_out,
   output logic [7:0]       status_out,
   // memory bus and decode
   output logic [15:0]      mem_addr_out,
   output logic             mem_rd_out,
   output logic             rom_sel_out,
   output logic             ram_sel_out,
   output logic             standby_sel_out,
   output logic             vector_sel_out,
   output logic [15:0]      reset_vector_out,
   // mode control
   output logic [7:0]       mode_control_out
);
   typedef struct packed {
      bbm_pkg::seq_state_t state;
      logic [15:0]         pc;
      logic [7:0]          opcode;
      logic [7:0]          zp;
      logic [7:0]          disp;
      logic                opnd_bit;
      logic                taken;
      logic                illegal;
      logic [15:0]         next_pc;
      logic [7:0]          status;
      logic [15:0]         addr;
      logic                rd;
      logic [7:0]          mode_ctrl;
   } exec_state_t;

   exec_state_t q;
   exec_state_t d;

   map_if   mif ();
   phase_if ph ();

   // =====================================================
   // submodules
   addr_map_decode #(
      .ROM_PRESENT  (ROM_PRESENT),
      .RESET_AT_ROM (RESET_AT_ROM)
   ) u_map (
      .m (mif.dec)
   );

   clk_countdown #(
      .DIV_BY_FOUR (DIV_BY_FOUR),
      .SLAVE_MODE  (SLAVE_MODE)
   ) u_clk (
      .sys_clk_in     (sys_clk_in),
      .reset_n_in     (reset_n_in),
      .osc_in         (oscillator_input_in),
      .osc_out_pin_in (oscillator_output_in),
      .phi2_pin_in    (phi2_in),
      .phi2_pin_out   (phi2_out),
      .phi2_oe_out    (phi2_oe_out),
      .p              (ph.gen)
   );

   // =====================================================
   // combinational helpers
   logic        legal_op;
   logic [2:0]  bit_idx;
   logic [15:0] follow_pc;
   logic [15:0] disp_ext;

   // legal bit branch: shared low nibble; bit 7 picks the sense
   assign legal_op  = (mem_data_in[bbm_pkg::OP_IDX_LO-1:0] == bbm_pkg::BBX_LOW_NIBBLE);
   assign bit_idx   = q.opcode[bbm_pkg::OP_IDX_HI:bbm_pkg::OP_IDX_LO];
   assign follow_pc = q.pc + bbm_pkg::BBX_LENGTH;
   assign disp_ext  = 16'($signed(q.disp));

   // =====================================================
   // next state; bus reads complete on each phase-two rising tick
   always_comb begin
      d = q;
      if (mode_wr_in) begin
         d.mode_ctrl = mode_data_in;
      end
      unique case (q.state)
         bbm_pkg::S_IDLE: begin
            if (exec_start_in) begin
               d.pc      = exec_pc_in;
               d.status  = status_in;
               d.addr    = exec_pc_in;
               d.rd      = 1'b1;
               d.taken   = 1'b0;
               d.illegal = 1'b0;
               d.state   = bbm_pkg::S_OPCODE;
            end
         end
         bbm_pkg::S_OPCODE: begin
            if (ph.tick) begin
               d.opcode = mem_data_in;
               if (legal_op) begin
                  d.addr  = q.pc + bbm_pkg::PC_STEP;
                  d.state = bbm_pkg::S_ZPADDR;
               end else begin
                  // not ours: hand back with pc past the opcode
                  d.illegal = 1'b1;
                  d.next_pc = q.pc + bbm_pkg::PC_STEP;
                  d.rd      = 1'b0;
                  d.state   = bbm_pkg::S_DONE;
               end
            end
         end
         bbm_pkg::S_ZPADDR: begin
            if (ph.tick) begin
               d.zp    = mem_data_in;
               d.addr  = q.addr + bbm_pkg::PC_STEP;
               d.state = bbm_pkg::S_DISP;
            end
         end
         bbm_pkg::S_DISP: begin
            if (ph.tick) begin
               d.disp  = mem_data_in;
               d.addr  = {bbm_pkg::ZERO_PAGE_HI, q.zp};
               d.state = bbm_pkg::S_OPERAND;
            end
         end
         bbm_pkg::S_OPERAND: begin
            if (ph.tick) begin
               d.opnd_bit = mem_data_in[bit_idx];
               // set-sense branches on a one, clear-sense on a zero
               d.taken = (mem_data_in[bit_idx] == q.opcode[bbm_pkg::OP_SENSE_BIT]);
               if (mem_data_in[bit_idx] == q.opcode[bbm_pkg::OP_SENSE_BIT]) begin
                  d.next_pc = follow_pc + disp_ext;
               end else begin
                  d.next_pc = follow_pc;
               end
               d.rd    = 1'b0;
               d.state = bbm_pkg::S_DONE;
            end
         end
         bbm_pkg::S_DONE: begin
            d.state = bbm_pkg::S_IDLE;
         end
         default: begin
            d.state = bbm_pkg::S_IDLE;
         end
      endcase
   end

   // =====================================================
   // state register; reset lands in idle with bus quiet
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         q           <= '0;
         q.mode_ctrl <= bbm_pkg::MODE_CTRL_RESET;
      end else begin
         q <= d;
      end
   end

   // =====================================================
   // outputs; standby select lets the core protect retained bytes
   assign mif.addr           = q.addr;
   assign exec_busy_out      = (q.state != bbm_pkg::S_IDLE);
   assign exec_done_out      = (q.state == bbm_pkg::S_DONE);
   assign branch_taken_out   = q.taken;
   assign not_bit_branch_out = q.illegal;
   assign next_pc_out        = q.next_pc;
   assign status_out         = q.status;
   assign mem_addr_out       = q.addr;
   assign mem_rd_out         = q.rd;
   assign rom_sel_out        = mif.rom_sel;
   assign ram_sel_out        = mif.ram_sel;
   assign standby_sel_out    = mif.standby_sel;
   assign vector_sel_out     = mif.vector_sel;
   assign reset_vector_out   = mif.reset_vector;
   assign mode_control_out   = q.mode_ctrl;

   // =====================================================
   // checks
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);

   sequence s_accept;
      q.state == bbm_pkg::S_IDLE && exec_start_in;
   endsequence

   sequence s_legal_opcode;
      q.state == bbm_pkg::S_OPCODE && ph.tick && legal_op;
   endsequence

   sequence s_resolve;
      q.state == bbm_pkg::S_OPERAND && ph.tick;
   endsequence

   // opcode byte that is not one of ours, seen on its tick
   sequence s_foreign_opcode;
      q.state == bbm_pkg::S_OPCODE && ph.tick && !legal_op;
   endsequence

   property p_fetch_start;
      s_accept |=> q.state == bbm_pkg::S_OPCODE && mem_rd_out
                   && mem_addr_out == $past(exec_pc_in);
   endproperty

   property p_zp_walk;
      s_legal_opcode |=> q.state == bbm_pkg::S_ZPADDR
                         && mem_addr_out == q.pc + bbm_pkg::PC_STEP;
   endproperty

   fetch_start_a: assert property (p_fetch_start)
      else $error("opcode fetch did not start at the given pc");
   zp_walk_a: assert property (p_zp_walk)
      else $error("legal opcode did not advance to the address byte");
   operand_addr_a: assert property (q.state == bbm_pkg::S_OPERAND
      |-> mem_addr_out[15:8] == bbm_pkg::ZERO_PAGE_HI && mem_addr_out[7:0] == q.zp)
      else $error("operand fetched outside zero page");
   set_taken_a: assert property (s_resolve ##1 (q.opcode[bbm_pkg::OP_SENSE_BIT])
      |-> exec_done_out && branch_taken_out == q.opnd_bit)
      else $error("branch-if-set decision wrong");
   clear_taken_a: assert property (s_resolve ##1 (!q.opcode[bbm_pkg::OP_SENSE_BIT])
      |-> exec_done_out && branch_taken_out == !q.opnd_bit)
      else $error("branch-if-clear decision wrong");
   fall_through_a: assert property (exec_done_out && !branch_taken_out && !not_bit_branch_out
      |-> next_pc_out == q.pc + bbm_pkg::BBX_LENGTH)
      else $error("untaken branch pc not past the instruction");
   branch_target_a: assert property (exec_done_out && branch_taken_out
      |-> next_pc_out == q.pc + bbm_pkg::BBX_LENGTH + {{8{q.disp[7]}}, q.disp})
      else $error("taken branch target wrong");
   status_hold_a: assert property (exec_busy_out && !$past(q.state == bbm_pkg::S_IDLE)
      |-> $stable(status_out))
      else $error("status changed during a bit branch");
   rom_map_a: assert property (mem_addr_out >= bbm_pkg::ROM_LO && mem_addr_out <= bbm_pkg::ROM_HI
      |-> rom_sel_out == ROM_PRESENT && !ram_sel_out)
      else $error("rom region decode wrong");
   ram_map_a: assert property (ram_sel_out
      |-> mem_addr_out[15:8] == bbm_pkg::ZERO_PAGE_HI && mem_addr_out >= bbm_pkg::RAM_LO)
      else $error("ram selected outside its range");
   standby_map_a: assert property (standby_sel_out |-> ram_sel_out
      && mem_addr_out <= bbm_pkg::STANDBY_HI)
      else $error("standby section decode wrong");
   vector_map_a: assert property (vector_sel_out |-> mem_addr_out >= bbm_pkg::VEC_LO
      && !rom_sel_out)
      else $error("vector decode wrong");
   reset_vector_a: assert property (reset_vector_out == bbm_pkg::RST_VEC_EXT
      || (ROM_PRESENT && reset_vector_out == bbm_pkg::RST_VEC_ROM))
      else $error("reset vector not at one of its allowed locations");
   master_drive_a: assert property (!SLAVE_MODE |-> phi2_oe_out ##1 phi2_oe_out)
      else $error("master stopped driving phase two");
   mode_write_a: assert property (mode_wr_in
      |=> mode_control_out == $past(mode_data_in))
      else $error("mode control write lost");
   // without a strobe the register must keep what software last put there
   mode_hold_a: assert property (!mode_wr_in |=> $stable(mode_control_out))
      else $error("mode control changed without a write");
   // a byte that is not a bit branch is handed back at once, pc past its single byte
   foreign_op_a: assert property (s_foreign_opcode |=> exec_done_out && not_bit_branch_out
      && !branch_taken_out && next_pc_out == q.pc + bbm_pkg::PC_STEP)
      else $error("foreign opcode not handed back past its byte");
   done_pulse_a: assert property (exec_done_out |=> !exec_done_out && !exec_busy_out)
      else $error("done lasted more than one cycle");
   read_release_a: assert property (exec_done_out |-> !mem_rd_out)
      else $error("read still requested after the decision");
   // reads complete only on a tick, so the address must not wander between ticks
   addr_hold_a: assert property (q.state != bbm_pkg::S_IDLE && !ph.tick
      |=> $stable(mem_addr_out))
      else $error("read address moved between phase-two ticks");
endmodule

// *** test/mem_osc_model.sv ***
// partner model: external memory on the block's read bus and a free-running oscillator source
`timescale 1ns/1ps
module mem_osc_model #(
   parameter int OSC_HALF_NS = 120
) (
   // memory bus from the block
   input  wire logic [15:0] mem_addr_in,
   input  wire logic        mem_rd_in,
   output logic [7:0]       mem_data_out,
   // oscillator source
   output logic             osc_out
);
   logic [7:0] mem [0:65535];
   logic [7:0] last_q;

   // =====================================================
   // memory: filled with an address pattern so stray reads never look like programmed bytes
   initial begin
      for (int a = 0; a < 65536; a++) begin
         mem[a] = a[7:0] ^ 8'h3c;
      end
      last_q = 8'h00;
   end

   // remember what the bus last carried
   always @(mem_addr_in or mem_rd_in) begin
      if (mem_rd_in) begin
         last_q = mem[mem_addr_in];
      end
   end

   // a released bus shows the inverse of the last byte, never a stale copy
   always_comb begin
      if (mem_rd_in) begin
         mem_data_out = mem[mem_addr_in];
      end else begin
         mem_data_out = ~last_q;
      end
   end

   // =====================================================
   // external source: runs free, offset so its edges never meet the system clock edges
   initial begin
      osc_out = 1'b0;
      #7;
      forever begin
         #(OSC_HALF_NS) osc_out = ~osc_out;
      end
   end
endmodule

// *** test/bit_branch_memory_map_clock_test.sv ***
// self-checking bench for the bit-branch sequencer, memory map decode and phase-two clock
`timescale 1ns/1ps
module bit_branch_memory_map_clock_test;
   localparam int OSC_HALF = 120;
   logic        sys_clk_in, reset_n_in, exec_start_in, mode_wr_in, oscillator_output_in;
   logic [15:0] exec_pc_in;
   logic [7:0]  status_in, mode_data_in, mem_data;
   logic        osc, phi2_out, phi2_oe_out, exec_busy_out, exec_done_out;
   logic        branch_taken_out, not_bit_branch_out, mem_rd_out;
   logic        rom_sel_out, ram_sel_out, standby_sel_out, vector_sel_out;
   logic [15:0] next_pc_out, mem_addr_out, reset_vector_out;
   logic [7:0]  status_out, mode_control_out;
   int          n_errors, samples_checked, cyc;

   // =====================================================
   // clock, cycle count and instances
   initial begin
      sys_clk_in = 1'b0;
      forever begin
         #20 sys_clk_in = ~sys_clk_in;
      end
   end
   always @(posedge sys_clk_in) cyc++;

   mem_osc_model #(.OSC_HALF_NS(OSC_HALF)) model (
      .mem_addr_in(mem_addr_out), .mem_rd_in(mem_rd_out), .mem_data_out(mem_data),
      .osc_out(osc));

   // the inverted phase-two loop is what a slave partner would see; ignored in a master build
   bit_branch_memory_map_clock uut (
      .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .exec_start_in(exec_start_in),
      .exec_pc_in(exec_pc_in), .status_in(status_in), .mem_data_in(mem_data),
      .mode_wr_in(mode_wr_in), .mode_data_in(mode_data_in), .oscillator_input_in(osc),
      .oscillator_output_in(oscillator_output_in), .phi2_in(~phi2_out),
      .phi2_out(phi2_out), .phi2_oe_out(phi2_oe_out), .exec_busy_out(exec_busy_out),
      .exec_done_out(exec_done_out), .branch_taken_out(branch_taken_out),
      .not_bit_branch_out(not_bit_branch_out), .next_pc_out(next_pc_out),
      .status_out(status_out), .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out),
      .rom_sel_out(rom_sel_out), .ram_sel_out(ram_sel_out),
      .standby_sel_out(standby_sel_out), .vector_sel_out(vector_sel_out),
      .reset_vector_out(reset_vector_out), .mode_control_out(mode_control_out));

   // =====================================================
   // compare, verdict
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // decode of whatever address the block is reading
   task automatic chk_decode(input logic [15:0] a);
      chk("rom sel", rom_sel_out, a >= 16'h7f00 && a <= 16'h7fff);
      chk("vector sel", vector_sel_out, a >= 16'hfffa);
      chk("ram sel", ram_sel_out, a >= 16'h0040 && a <= 16'h00ff);
      chk("standby sel", standby_sel_out, a >= 16'h0040 && a <= 16'h005f);
   endtask

   // =====================================================
   // one bit branch; a second start with another pc is held up while busy and must be ignored
   task automatic run_bbx(input logic [15:0] pc, input logic [7:0] op, zp, disp, opnd, st);
      logic [15:0] exp_pc;
      logic        exp_tk;
      logic        legal;
      logic [15:0] seen [$];
      int          k;
      model.mem[pc] = op;
      model.mem[pc + 16'h0001] = zp;
      model.mem[pc + 16'h0002] = disp;
      model.mem[{8'h00, zp}] = opnd;
      legal = (op[3:0] == 4'hf);
      exp_tk = legal && (opnd[op[6:4]] == op[7]);
      exp_pc = legal ? pc + 16'h0003 : pc + 16'h0001;
      if (exp_tk) begin
         exp_pc = exp_pc + {{8{disp[7]}}, disp};
      end
      exec_pc_in = pc;
      status_in = st;
      exec_start_in = 1'b1;
      // watch from the first edge on; the start stays up over a second edge with another pc
      for (k = 0; k < 600; k++) begin
         @(negedge sys_clk_in);
         if (mem_rd_out === 1'b1) begin
            chk_decode(mem_addr_out);
            if (seen.size() == 0 || seen[$] !== mem_addr_out) begin
               seen.push_back(mem_addr_out);
            end
         end
         if (exec_done_out === 1'b1) begin
            break;
         end
         if (k == 0) begin
            exec_pc_in = ~pc;
         end
         if (k == 1) begin
            exec_start_in = 1'b0;
         end
      end
      exec_start_in = 1'b0;
      if (k == 600) begin
         n_errors++;
         conclude();
      end
      chk("taken", branch_taken_out, exp_tk);
      chk("next pc", next_pc_out, exp_pc);
      chk("not bit branch", not_bit_branch_out, !legal);
      chk("status", status_out, st);
      chk("read released", mem_rd_out, 1'b0);
      chk("opcode addr", seen[0], pc);
      if (legal) begin
         chk("fetch count", seen.size(), 4);
         chk("zp addr", seen[1], pc + 16'h0001);
         chk("disp addr", seen[2], pc + 16'h0002);
         chk("operand addr", seen[3], {8'h00, zp});
      end else begin
         chk("fetch count", seen.size(), 1);
      end
      @(negedge sys_clk_in);
      chk("done width", exec_done_out, 1'b0);
      chk("idle again", exec_busy_out, 1'b0);
   endtask

   // every bit index, both senses, taken and untaken, forward and backward displacement
   task automatic bit_sweep();
      for (int b = 0; b < 8; b++) begin
         for (int s = 0; s < 2; s++) begin
            run_bbx(16'h7f10, {s[0], b[2:0], 4'hf}, 8'h45, b[0] ? 8'h80 : 8'h7f,
                    b[0] ? ~(8'h01 << b) : (8'h01 << b), 8'ha5 ^ b[7:0]);
         end
      end
   endtask

   // =====================================================
   // mode control register, back-to-back writes
   task automatic mode_ctrl_test();
      mode_wr_in = 1'b1;
      mode_data_in = 8'h5a;
      @(negedge sys_clk_in);
      chk("mode control", mode_control_out, 8'h5a);
      mode_data_in = 8'ha5;
      @(negedge sys_clk_in);
      chk("mode control", mode_control_out, 8'ha5);
      mode_wr_in = 1'b0;
      @(negedge sys_clk_in);
      chk("mode control hold", mode_control_out, 8'ha5);
   endtask

   // =====================================================
   // phase-two period, rise to rise, in system cycles
   task automatic rise_at(output int t);
      logic p;
      p = phi2_out;
      for (int i = 0; i < 100; i++) begin
         @(negedge sys_clk_in);
         if (phi2_out === 1'b1 && p === 1'b0) begin
            t = cyc;
            return;
         end
         p = phi2_out;
      end
      n_errors++;
      conclude();
   endtask

   task automatic period_test(input logic byp, input int exp);
      int t0;
      int t1;
      oscillator_output_in = byp;
      repeat (40) @(negedge sys_clk_in);
      rise_at(t0);
      rise_at(t1);
      chk("phi2 period", t1 - t0, exp);
      chk("phi2 drive", phi2_oe_out, 1'b1);
   endtask

   // =====================================================
   // main sequence
   initial begin
      reset_n_in = 1'b0;
      exec_start_in = 1'b0;
      exec_pc_in = 16'h0000;
      status_in = 8'h00;
      mode_wr_in = 1'b0;
      mode_data_in = 8'h00;
      oscillator_output_in = 1'b1;
      n_errors = 0;
      samples_checked = 0;
      cyc = 0;
      repeat (5) @(negedge sys_clk_in);
      chk("reset busy", exec_busy_out, 1'b0);
      chk("reset addr", mem_addr_out, 16'h0000);
      chk_decode(16'h0000);
      chk("reset mode", mode_control_out, 8'h00);
      chk("reset vector", reset_vector_out, 16'hfffc);
      reset_n_in = 1'b1;
      @(negedge sys_clk_in);
      bit_sweep();
      run_bbx(16'hfffa, 8'hff, 8'h80, 8'h10, 8'h80, 8'h01);
      run_bbx(16'h0300, 8'h0f, 8'h12, 8'hfe, 8'hfe, 8'hff);
      run_bbx(16'h1234, 8'h47, 8'h50, 8'h00, 8'h00, 8'h3c);
      mode_ctrl_test();
      // divide by two: two oscillator periods per phase; bypass: one; 40 ns per system cycle
      period_test(1'b1, 4 * OSC_HALF / 40);
      period_test(1'b0, 2 * OSC_HALF / 40);
      conclude();
   end
endmodule
